// file: logic/lcd_drive_sequencer.sv
// Multiplexed LCD common and segment drive sequencer
//
// Overview of operation
// - Active commons: static 1, duplex 2, triplex 3, quadruplex 4
// - Each segment line serves one segment per common
// - Duplex frame has four slots, static two
// - Duplex commons use ground, middle, top levels
// - Duplex segment states come from nibble bits 0,1
// - Bit0 rules slots t1,t2; bit1 rules t3,t4
// - Selected common swings top to ground
// - Segment out of phase is on, in phase off
// - Every frame averages zero volts per segment
// - Multiplex modes use half-bias middle level
// - Memory one means on, zero means off
// - Mode limits which nibble bits are read
`timescale 1ns/10ps
module lcd_drive_sequencer
    import lcd_drive_pkg::*;
#(
    parameter int SEGMENTS = 32,
    parameter int SLOT_DIVIDE = SLOT_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Configuration and display memory
    input wire mode_e mode,
    input wire logic [SEGMENTS*NIBBLE_BITS-1:0] dispMem,
    // Drive level selects to the analog stage
    output level_e comLevel [MAX_COMMONS],
    output level_e segLevel [SEGMENTS],
    // Slot status
    output logic [2:0] slotNum,
    output logic frameStart
);
    initial
    begin
        if (SEGMENTS < 1 || SEGMENTS > 64)
            $error("lcd_drive_sequencer: SEGMENTS out of range");
        if (SLOT_DIVIDE < 1 || SLOT_DIVIDE > 65536)
            $error("lcd_drive_sequencer: SLOT_DIVIDE out of range");
    end

    logic tick;
    slot_sel_s sel_ff;
    slot_sel_s nxt_sel;
    level_e comLevel_ff [MAX_COMMONS];
    level_e nxt_comLevel [MAX_COMMONS];
    level_e segLevel_ff [SEGMENTS];
    level_e nxt_segLevel [SEGMENTS];
    logic frameStart_ff;
    logic nxt_frameStart;

    lcd_slot_timer #(
        .DIVIDE(SLOT_DIVIDE)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    // Number of commons in use for a mode
    function automatic logic [2:0] commonsOf(input mode_e m);
        case (m)
            MODE_STATIC: commonsOf = 3'h1;
            MODE_DUPLEX: commonsOf = 3'h2;
            MODE_TRIPLEX: commonsOf = 3'h3;
            MODE_QUAD: commonsOf = 3'h4;
            default: commonsOf = 3'h1;
        endcase
    endfunction

    // Index of the final slot of a frame for a mode
    function automatic logic [2:0] lastSlotOf(input mode_e m);
        lastSlotOf = 3'(int'(commonsOf(m)) * SLOTS_PER_COMMON - 1);
    endfunction

    // Frame layout: each common owns two consecutive slots, high then low phase
    always_comb
    begin
        logic [2:0] last;
        last = lastSlotOf(mode);
        nxt_sel = sel_ff;
        nxt_frameStart = 1'b0;
        if (tick)
        begin
            if (sel_ff.slot >= last)
            begin
                nxt_sel.slot = SLOT_RESET;
                nxt_frameStart = 1'b1;
            end
            else
                nxt_sel.slot = sel_ff.slot + 3'h1;
        end
        nxt_sel.com = nxt_sel.slot[2:1];
        nxt_sel.phase = nxt_sel.slot[0];
    end

    // Level selects computed for the coming slot, loaded together
    always_comb
    begin
        level_e selHigh;
        level_e selLow;
        logic bitOn;
        bitOn = 1'b0;
        selHigh = nxt_sel.phase ? LVL_GND : LVL_TOP;
        selLow = nxt_sel.phase ? LVL_TOP : LVL_GND;
        for (int c = 0; c < MAX_COMMONS; c++)
        begin
            if (3'(c) >= commonsOf(mode))
                nxt_comLevel[c] = LVL_GND;
            else if (2'(c) == nxt_sel.com)
                nxt_comLevel[c] = selHigh;
            else
                nxt_comLevel[c] = LVL_MID;
        end
        for (int s = 0; s < SEGMENTS; s++)
        begin
            // Only the bit of the active common is read; higher bits stay unused
            bitOn = dispMem[s*NIBBLE_BITS + int'(nxt_sel.com)];
            // On drives opposite to the common, off follows it; both swing
            // symmetrically across the slot pair so the frame averages zero
            nxt_segLevel[s] = bitOn ? selLow : selHigh;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_ff <= '0;
            frameStart_ff <= 1'b0;
            for (int c = 0; c < MAX_COMMONS; c++)
                comLevel_ff[c] <= LVL_MID;
            for (int s = 0; s < SEGMENTS; s++)
                segLevel_ff[s] <= LVL_MID;
        end
        else
        begin
            sel_ff <= nxt_sel;
            frameStart_ff <= nxt_frameStart;
            if (tick)
            begin
                comLevel_ff <= nxt_comLevel;
                segLevel_ff <= nxt_segLevel;
            end
        end
    end

    assign comLevel = comLevel_ff;
    assign segLevel = segLevel_ff;
    assign slotNum = sel_ff.slot;
    assign frameStart = frameStart_ff;

    // Level outputs only move on a slot tick
    hold_between_a: assert property (@(posedge clk) disable iff (!rstn)
        !$past(tick) |-> $stable(comLevel_ff[0]) && $stable(segLevel_ff[0]))
        else $error("levels changed inside a slot");

    // Duplex frame has four slots
    duplex_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
        tick && mode == MODE_DUPLEX && $stable(mode) && sel_ff.slot == 3'h3
        |=> sel_ff.slot == 3'h0)
        else $error("duplex frame not four slots");

    // Static frame has two slots
    static_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
        tick && mode == MODE_STATIC && sel_ff.slot == 3'h1 |=> sel_ff.slot == 3'h0)
        else $error("static frame not two slots");

    // Selected common swings between rails
    com_swing_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(tick) && sel_ff.com == 2'h0 |-> comLevel_ff[0] != LVL_MID)
        else $error("selected common not at rail");

    // Unselected active common rests at middle level
    com_rest_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(tick) && mode == MODE_DUPLEX && $stable(mode) && sel_ff.com == 2'h1
        |-> comLevel_ff[0] == LVL_MID)
        else $error("idle common not at middle");

    // Segment on is opposite to its common, off equal
    seg_phase_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(tick) && sel_ff.com == 2'h0 && $stable(dispMem[0])
        |-> (segLevel_ff[0] != comLevel_ff[0]) == dispMem[0])
        else $error("segment phase wrong");

    // Segment never sits at middle after first tick
    seg_rail_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(tick) |-> segLevel_ff[0] != LVL_MID)
        else $error("segment at middle level");

    // Active common count follows mode
    com_count_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(tick) && mode == MODE_STATIC && $stable(mode) |-> comLevel_ff[1] == LVL_GND)
        else $error("unused common driven");

    // Cycles since the last tick, kept only for checking the slot length
    logic [15:0] slotAge_ff;
    logic [15:0] nxt_slotAge;

    always_comb
    begin
        if (tick)
            nxt_slotAge = 16'h0000;
        else if (slotAge_ff == 16'hFFFF)
            nxt_slotAge = slotAge_ff;
        else
            nxt_slotAge = slotAge_ff + 16'h0001;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            slotAge_ff <= TICK_DIV_RESET;
        else
            slotAge_ff <= nxt_slotAge;
    end

    // Every slot lasts exactly the divider's count of cycles
    slot_len_a: assert property (@(posedge clk) disable iff (!rstn)
        tick |-> int'(slotAge_ff) == SLOT_DIVIDE - 1)
        else $error("slot length wrong");

    // No slot overstays the divider's count
    slot_due_a: assert property (@(posedge clk) disable iff (!rstn)
        int'(slotAge_ff) < SLOT_DIVIDE)
        else $error("slot tick overdue");

    // After any tick the slot lies inside the frame of the current mode
    slot_range_a: assert property (@(posedge clk) disable iff (!rstn)
        $past(tick) && $stable(mode) |-> sel_ff.slot <= lastSlotOf(mode))
        else $error("slot beyond end of frame");

    // Between ticks the slot counter holds
    slot_still_a: assert property (@(posedge clk) disable iff (!rstn)
        !tick |=> $stable(sel_ff.slot))
        else $error("slot moved without a tick");

    // Inside a frame a tick steps to the next slot
    slot_step_a: assert property (@(posedge clk) disable iff (!rstn)
        tick && sel_ff.slot < lastSlotOf(mode) |=> sel_ff.slot == $past(sel_ff.slot) + 3'h1)
        else $error("slot did not step by one");

    // A frame start pulse marks the first cycle of slot zero after a tick
    frame_mark_a: assert property (@(posedge clk) disable iff (!rstn)
        frameStart_ff |-> $past(tick) && sel_ff.slot == SLOT_RESET)
        else $error("frame start away from slot zero");

    // The frame start pulse lasts one cycle
    frame_single_a: assert property (@(posedge clk) disable iff (!rstn)
        frameStart_ff |=> !frameStart_ff)
        else $error("frame start longer than a cycle");

    // A wrap from the last slot raises the frame start
    frame_raise_a: assert property (@(posedge clk) disable iff (!rstn)
        tick && sel_ff.slot >= lastSlotOf(mode) |=> frameStart_ff)
        else $error("frame start missing at wrap");

    // Per-common checks: hold inside a slot, rest levels, rail swing when selected
    for (genvar gc = 0; gc < MAX_COMMONS; gc++)
    begin : g_com_chk
        // A common moves only on a slot tick
        com_hold_a: assert property (@(posedge clk) disable iff (!rstn)
            !$past(tick) |-> $stable(comLevel_ff[gc]))
            else $error("common level changed inside a slot");

        // Commons beyond the mode's count sit at ground
        com_unused_a: assert property (@(posedge clk) disable iff (!rstn)
            $past(tick) && $stable(mode) && 3'(gc) >= commonsOf(mode)
            |-> comLevel_ff[gc] == LVL_GND)
            else $error("unused common not at ground");

        // The selected common sits on a rail, top first then ground
        com_select_a: assert property (@(posedge clk) disable iff (!rstn)
            $past(tick) && $stable(mode) && 3'(gc) < commonsOf(mode) && sel_ff.com == 2'(gc)
            |-> comLevel_ff[gc] == (sel_ff.phase ? LVL_GND : LVL_TOP))
            else $error("selected common off its rail");

        // An active common outside its own slots rests at the middle level
        com_middle_a: assert property (@(posedge clk) disable iff (!rstn)
            $past(tick) && $stable(mode) && 3'(gc) < commonsOf(mode) && sel_ff.com != 2'(gc)
            |-> comLevel_ff[gc] == LVL_MID)
            else $error("idle common not at middle");
    end

    // Per-segment checks: hold inside a slot, always on a rail, phase against memory
    for (genvar gs = 0; gs < SEGMENTS; gs++)
    begin : g_seg_chk
        // A segment moves only on a slot tick
        seg_hold_a: assert property (@(posedge clk) disable iff (!rstn)
            !$past(tick) |-> $stable(segLevel_ff[gs]))
            else $error("segment level changed inside a slot");

        // Segments never rest at the middle level once slots run
        seg_swing_a: assert property (@(posedge clk) disable iff (!rstn)
            $past(tick) |-> segLevel_ff[gs] != LVL_MID)
            else $error("segment left at middle level");

        // Against the selected common: opposite when its bit is set, equal when clear
        seg_onoff_a: assert property (@(posedge clk) disable iff (!rstn)
            $past(tick) && $stable(dispMem[gs*NIBBLE_BITS +: NIBBLE_BITS])
            |-> (segLevel_ff[gs] != (sel_ff.phase ? LVL_GND : LVL_TOP))
                == dispMem[gs*NIBBLE_BITS + int'(sel_ff.com)])
            else $error("segment phase against its common wrong");
    end
endmodule

// file: logic/lcd_drive_pkg.sv
// Shared constants and types for the multiplexed LCD drive sequencer
package lcd_drive_pkg;
    // Drive level codes sent to the analog bias and driver stage
    typedef enum logic [1:0] {
        LVL_GND,
        LVL_MID,
        LVL_TOP
    } level_e;

    // Line-count modes
    typedef enum logic [1:0] {
        MODE_STATIC,
        MODE_DUPLEX,
        MODE_TRIPLEX,
        MODE_QUAD
    } mode_e;

    localparam int MAX_COMMONS = 4;
    localparam int NIBBLE_BITS = 4;
    localparam int SLOTS_PER_COMMON = 2;
    localparam logic [2:0] SLOT_RESET = 3'h0;
    localparam logic [15:0] TICK_DIV_RESET = 16'h0000;

    // Slot-rate timing: one slot lasts this long at the 10 MHz clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int SLOT_TIME_US = 2000;
    localparam int SLOT_CYCLES = (SLOT_TIME_US * 1000) / CLK_PERIOD_NS;

    // Per-slot selection state carried from sequencer to output stage
    typedef struct packed {
        logic [1:0] com;
        logic phase;
        logic [2:0] slot;
    } slot_sel_s;
endpackage

// file: logic/lcd_slot_timer.sv
// Slot-rate tick generator
`timescale 1ns/10ps
module lcd_slot_timer
    import lcd_drive_pkg::*;
#(
    parameter int DIVIDE = SLOT_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Tick output
    output logic tick
);
    logic [15:0] count_ff;
    logic [15:0] nxt_count;

    initial
    begin
        if (DIVIDE < 1 || DIVIDE > 65536)
            $error("lcd_slot_timer: DIVIDE out of range");
    end

    always_comb
    begin
        tick = (count_ff == 16'(DIVIDE - 1));
        nxt_count = tick ? 16'h0000 : count_ff + 16'h0001;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            count_ff <= TICK_DIV_RESET;
        else
            count_ff <= nxt_count;
    end
endmodule

// file: tb/lcd_glass_model.sv
// Glass model: integrates common-minus-segment drive per pixel over each frame
`timescale 1ns/10ps
module lcd_glass_model
    import lcd_drive_pkg::*;
#(
    parameter int SEGMENTS = 4
)
(
    // Clock
    input wire logic clk,
    // Drive from the sequencer
    input wire mode_e mode,
    input wire level_e comLevel [MAX_COMMONS],
    input wire level_e segLevel [SEGMENTS],
    input wire logic frameStart,
    // Verdict on the previous frame
    output logic [SEGMENTS*NIBBLE_BITS-1:0] litMask,
    output logic dcFault
);
    int sum [SEGMENTS][MAX_COMMONS];
    int sq [SEGMENTS][MAX_COMMONS];
    int cyc = 0;
    int d;
    always @(posedge clk)
    begin
        if (frameStart)
        begin
            dcFault <= 1'b0;
            for (int s = 0; s < SEGMENTS; s++)
                for (int c = 0; c < MAX_COMMONS; c++)
                begin
                    // Lit when drive energy exceeds one level step per cycle
                    litMask[s*4+c] <= (c <= int'(mode)) && (sq[s][c] > cyc);
                    if (c <= int'(mode) && sum[s][c] != 0)
                        dcFault <= 1'b1;
                    sum[s][c] = 0;
                    sq[s][c] = 0;
                end
            cyc = 0;
        end
        for (int s = 0; s < SEGMENTS; s++)
            for (int c = 0; c < MAX_COMMONS; c++)
            begin
                d = int'(comLevel[c]) - int'(segLevel[s]);
                sum[s][c] += d;
                sq[s][c] += d * d;
            end
        cyc++;
    end
endmodule

// file: tb/lcd_drive_sequencer_tb_top.sv
// Self-checking bench for the LCD drive sequencer with a glass model
`timescale 1ns/10ps
module lcd_drive_sequencer_tb_top;
    import lcd_drive_pkg::*;
    localparam int SEGS = 4;
    localparam int DIV = 4;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    mode_e mode = MODE_DUPLEX;
    logic [SEGS*NIBBLE_BITS-1:0] dispMem = '0;
    level_e comLevel [MAX_COMMONS];
    level_e segLevel [SEGS];
    logic [2:0] slotNum;
    logic frameStart;
    logic [SEGS*NIBBLE_BITS-1:0] litMask;
    logic dcFault;
    int fails = 0;
    int compares = 0;
    int seed = 32'h8D85157E;
    logic chkOn = 1'b0;
    logic [2:0] prevSlot = 3'h0;
    int run = 0;

    lcd_drive_sequencer #(.SEGMENTS(SEGS), .SLOT_DIVIDE(DIV)) u_dut (.clk(clk), .rstn(rstn),
        .mode(mode), .dispMem(dispMem), .comLevel(comLevel), .segLevel(segLevel),
        .slotNum(slotNum), .frameStart(frameStart));
    lcd_glass_model #(.SEGMENTS(SEGS)) u_glass (.clk(clk), .mode(mode), .comLevel(comLevel),
        .segLevel(segLevel), .frameStart(frameStart), .litMask(litMask), .dcFault(dcFault));

    always #50 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic level_e exp_com(mode_e m, logic [2:0] sl, int c);
        if (c > int'(m))
            return LVL_GND;
        if (c == int'(sl >> 1))
            return sl[0] ? LVL_GND : LVL_TOP;
        return LVL_MID;
    endfunction

    function automatic level_e exp_seg(logic [2:0] sl, logic [3:0] nib);
        return (nib[sl >> 1] ^ sl[0]) ? LVL_GND : LVL_TOP;
    endfunction

    always @(negedge clk)
    begin
        run++;
        if (slotNum !== prevSlot)
        begin
            if (chkOn)
            begin
                check("slotNum", 16'(slotNum), 16'((int'(prevSlot) + 1) % (2 * int'(mode) + 2)));
                check("slotLength", 16'(run), 16'(DIV));
            end
            prevSlot = slotNum;
            run = 0;
        end
        if (chkOn)
        begin
            check("frameStart", 16'(frameStart), 16'(slotNum == 3'h0 && run == 0));
            for (int c = 0; c < MAX_COMMONS; c++)
                check("comLevel", 16'(comLevel[c]), 16'(exp_com(mode, slotNum, c)));
            for (int s = 0; s < SEGS; s++)
                check("segLevel", 16'(segLevel[s]), 16'(exp_seg(slotNum, dispMem[s*4 +: 4])));
            if (frameStart === 1'b1)
            begin
                check("litMask", 16'(litMask), 16'(dispMem & {SEGS{4'(4'hF >> (3 - int'(mode)))}}));
                check("dcFault", 16'(dcFault), 16'h0000);
            end
        end
    end

    task automatic apply(input mode_e m, input logic [15:0] d);
        chkOn = 1'b0;
        @(negedge clk);
        mode = m;
        dispMem = d;
        repeat (80) @(negedge clk);
        chkOn = 1'b1;
        repeat (96) @(negedge clk);
    endtask

    task automatic reset_check();
        chkOn = 1'b0;
        @(negedge clk);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        for (int c = 0; c < MAX_COMMONS; c++)
            check("comReset", 16'(comLevel[c]), 16'(LVL_MID));
        check("segReset", 16'(segLevel[0]), 16'(LVL_MID));
        check("slotReset", 16'(slotNum), 16'h0000);
        rstn = 1'b1;
    endtask

    task automatic end_of_test();
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #5000000;
        fails++;
        end_of_test();
    end

    initial
    begin
        reset_check();
        for (int m = 0; m < 4; m++)
        begin
            apply(mode_e'(m), 16'hFFFF);
            apply(mode_e'(m), 16'h0000);
            apply(mode_e'(m), 16'($random(seed)));
        end
        apply(MODE_DUPLEX, 16'h5A3C);
        reset_check();
        apply(MODE_QUAD, 16'($random(seed)));
        end_of_test();
    end
endmodule
